// ---- bench/rgb_delay_serial_control_bench.sv ----
`default_nettype none
module rgb_delay_serial_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rgbdsc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rgbdsc_code_t red;
  rgbdsc_code_t green;
  rgbdsc_code_t blue;
  // Entry 3 stays zero: colour 11 holds nothing
  rgbdsc_code_t exp_code [4] = '{default: 6'h00};
  int miscompares = 0;
  int num_checks = 0;
  always #2 i_clk = ~i_clk;
  rgbdsc_if lnk ();
  rgbdsc_host #(.QUARTER(6)) i_rgbdsc_host (.i_clk(i_clk), .i_reset(i_reset),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .lnk(lnk.host));
  rgbdsc_device i_rgbdsc_device (.i_clk(i_clk), .i_reset(i_reset), .lnk(lnk.device),
    .o_red_code(red), .o_green_code(green), .o_blue_code(blue));
  rgbdsc_sva i_rgbdsc_sva (.i_clk(i_clk), .i_reset(i_reset), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .sda(lnk.sda), .dev_sda_oe(lnk.dev_sda_oe),
    .analog_mode(lnk.analog_mode), .bus_type_select_pin(lnk.bus_type_select_pin),
    .address_select_high_pin(lnk.address_select_high_pin),
    .address_select_low_pin(lnk.address_select_low_pin));
  // ------------
  // Helpers
  // ------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Entered just after a rising edge; leaves one edge after release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask
  function automatic logic [31:0] ctrl_word(input logic rd, input logic [1:0] col,
      input logic spi, input logic ana, input logic [1:0] pins, input rgbdsc_code_t code);
    return {18'h0, code, pins, ana, spi, col, rd, 1'b1};
  endfunction
  task automatic run_op(input logic [31:0] w, output logic [31:0] st);
    logic err;
    int n;
    apb(1'b1, CTRL_OFS, w, st, err);
    n = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0, st, err);
      n++;
    end while (st[STAT_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic check_codes();
    check("red code", {26'h0, red}, {26'h0, exp_code[0]});
    check("green code", {26'h0, green}, {26'h0, exp_code[1]});
    check("blue code", {26'h0, blue}, {26'h0, exp_code[2]});
  endtask
  // Write then read back one colour over the chosen bus
  task automatic write_read(input logic spi, input logic [1:0] col, input rgbdsc_code_t code,
      input logic [1:0] pins);
    logic [31:0] st;
    run_op(ctrl_word(1'b0, col, spi, 1'b0, pins, code), st);
    if (col != 2'h3) exp_code[col] = code;
    check_codes();
    run_op(ctrl_word(1'b1, col, spi, 1'b0, pins, 6'h00), st);
    check("read status", st & 32'h3F03, {18'h0, exp_code[col], 8'h00});
  endtask
  // ------------
  // Main sequence
  // ------------
  initial begin
    logic [31:0] rd;
    logic [31:0] w;
    logic err;
    rgbdsc_code_t corner [6];
    corner = '{6'h3F, 6'h00, 6'h2A, 6'h15, 6'h01, 6'h3E};
    rd = $urandom(32'h00C1);
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    check_codes();
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    check("control reset", rd, CTRL_RST);
    // Go bit left low so no transfer starts
    w = $urandom & 32'hFFFF_FFDE;
    apb(1'b1, CTRL_OFS, w, rd, err);
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    check("control readback", rd, w & CTRL_WMASK);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, rd, err);
    check("unmapped write error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    check("unmapped read", {rd[30:0], err}, 32'h1);
    apb(1'b1, STAT_OFS, 32'hFFFF_FFFF, rd, err);
    check("status write error", {31'h0, err}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      if (i > 3) corner[i] = 6'($urandom);
      write_read(1'b1, 2'(i % 3), corner[i], 2'($urandom));
    end
    for (int p = 0; p < 4; p++) begin
      write_read(1'b0, 2'($urandom_range(2, 0)), 6'($urandom), 2'(p));
      write_read(1'b0, 2'(p % 3), corner[p], 2'(p));
    end
    write_read(1'b1, 2'h3, 6'($urandom), 2'h0);
    write_read(1'b0, 2'h3, 6'($urandom), 2'h1);
    run_op(ctrl_word(1'b0, 2'h0, 1'b0, 1'b1, 2'h0, ~exp_code[0]), rd);
    check("analog no ack", rd & 32'h3, 32'h2);
    check_codes();
    run_op(ctrl_word(1'b0, 2'h1, 1'b0, 1'b0, 2'h2, 6'h3F), rd);
    exp_code[1] = 6'h3F;
    check_codes();
    final_report();
  end
endmodule
`default_nettype wire

// ---- bench/rgbdsc_sva.sv ----
`default_nettype none
module rgbdsc_sva
  import rgbdsc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Link lines
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic analog_mode,
  input wire logic bus_type_select_pin,
  input wire logic address_select_high_pin,
  input wire logic address_select_low_pin
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ------------
  // Frame trackers
  // ------------
  logic sclk_q;
  logic sda_q;
  logic [4:0] spi_cnt_q;
  logic [15:0] spi_sh_q;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_sh_q;
  logic i2c_first_q;
  wire sclk_rise = sclk & ~sclk_q;
  wire i2c_start = sclk & sclk_q & sda_q & ~sda;
  wire [6:0] own_addr = {I2C_BASE[6:2], address_select_high_pin, address_select_low_pin};
  always_ff @(posedge i_clk) begin
    sclk_q <= i_reset | sclk;
    sda_q <= i_reset | sda;
  end
  // Counter clears with select high, so an aborted frame never leaks into the next
  always_ff @(posedge i_clk) begin
    if (i_reset || cs_n) begin
      spi_cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      spi_cnt_q <= spi_cnt_q + 5'h01;
      spi_sh_q <= {spi_sh_q[14:0], mosi};
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset || i2c_start) begin
      i2c_cnt_q <= 4'h0;
      i2c_first_q <= 1'b1;
    end else if (sclk_rise && i2c_cnt_q == I2C_ACK_BIT) begin
      i2c_cnt_q <= 4'h0;
      i2c_first_q <= 1'b0;
    end else if (sclk_rise) begin
      i2c_cnt_q <= i2c_cnt_q + 4'h1;
      i2c_sh_q <= {i2c_sh_q[6:0], sda};
    end
  end
  // ------------
  // Properties
  // ------------
  a_spi_frame_len: assert property (
    $rose(cs_n) && bus_type_select_pin |-> spi_cnt_q == 5'h10)
    else $error("SPI frame not sixteen clocks");
  a_spi_cmd_zeros: assert property (
    $rose(cs_n) && bus_type_select_pin |-> spi_sh_q[14:10] == 5'h00)
    else $error("SPI instruction bits 6 to 2 not zero");
  a_spi_start_mode: assert property (
    $fell(cs_n) |-> bus_type_select_pin)
    else $error("SPI select asserted in I2C mode");
  a_i2c_addr_ack: assert property (
    sclk_rise && i2c_cnt_q == I2C_ACK_BIT && i2c_first_q && !bus_type_select_pin
    && !analog_mode |-> sda == (i2c_sh_q[7:1] != own_addr))
    else $error("address acknowledge wrong");
  a_oe_rise_low: assert property (
    $rose(dev_sda_oe) |-> !sclk)
    else $error("device took data line while clock high");
  a_oe_steady_high: assert property (
    sclk && $past(sclk, 6) |-> $stable(dev_sda_oe))
    else $error("device data line changed in clock high phase");
  a_spi_no_sda: assert property (
    bus_type_select_pin && $past(bus_type_select_pin, 8) |-> !dev_sda_oe)
    else $error("device pulled data line in SPI mode");
  a_analog_silent: assert property (
    analog_mode && $past(analog_mode, 8) |-> !dev_sda_oe)
    else $error("device pulled data line in analog mode");
endmodule
`default_nettype wire

// ---- include/rgbdsc_if.sv ----
`default_nettype none
interface rgbdsc_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  logic analog_mode;
  logic bus_type_select_pin;
  logic address_select_high_pin;
  logic address_select_low_pin;
  // Open-drain data line with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (
    output sclk, cs_n, mosi, host_sda_o, host_sda_oe,
    output analog_mode, bus_type_select_pin,
    output address_select_high_pin, address_select_low_pin,
    input miso, sda
  );
  modport device (
    input sclk, cs_n, mosi, sda, analog_mode, bus_type_select_pin,
    input address_select_high_pin, address_select_low_pin,
    output miso, dev_sda_o, dev_sda_oe
  );
endinterface
`default_nettype wire

// ---- include/rgbdsc_pkg.sv ----
// Operation
// R1: Host selects digital control, then picks bus.
// R2: Each channel holds a code 0 to 63.
// R3: Colour 00 red, 01 green, 10 blue.
// R4: SPI uses four lines, full duplex.
// R5: SPI traffic counts only while select low.
// R6: SPI transaction is instruction then data byte.
// R7: SPI samples and launches on rising, MSB first.
// R8: Instruction: direction bit 7, colour bits 1:0.
// R9: SPI write stores data bits 5 to 0.
// R10: SPI read returns code in bits 5:0.
// R11: I2C data pulled low only for ack/data.
// R12: I2C address is base plus two pins.
// R13: I2C write: address, colour, code.
// R14: I2C read: address, colour, address, code.
// R15: First I2C byte: address plus direction.
// R16: Second I2C byte selects the colour.
// R17: Third write byte is the delay code.
// R18: Read returns code after repeated address.
// R19: Select high abandons partial SPI transfer.
// R20: Channels independent, last written code, zero reset.
`default_nettype none
package rgbdsc_pkg;
  // ----------------------------------------
  // Link timing
  // ----------------------------------------
  localparam int CLK_NS = 4;
  localparam int QUARTER_NS = 32;
  localparam int QUARTER_CYC = (QUARTER_NS / CLK_NS < 1) ? 1 : QUARTER_NS / CLK_NS;
  // ----------------------------------------
  // Serial format
  // ----------------------------------------
  localparam int CODE_W = 6;
  localparam int NUM_CH = 3;
  localparam logic [6:0] I2C_BASE = 7'h38;
  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_BLUE = 2'h2;
  localparam int RW_POS = 7;
  localparam logic [3:0] SPI_LAST_BIT = 4'hF;
  localparam logic [3:0] INS_LAST_BIT = 4'h7;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  typedef logic [CODE_W-1:0] rgbdsc_code_t;
  localparam rgbdsc_code_t CODE_RST = 6'h00;
  // ----------------------------------------
  // Host register map
  // ----------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_COL = 2;
  localparam int CTRL_SPI = 4;
  localparam int CTRL_ANA = 5;
  localparam int CTRL_ALO = 6;
  localparam int CTRL_AHI = 7;
  localparam int CTRL_CODE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_3FFE;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_CODE = 8;
endpackage
`default_nettype wire

// ---- verilog/rgbdsc_device.sv ----
`default_nettype none
module rgbdsc_device (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Serial link
  rgbdsc_if.device lnk,
  // Delay codes to the analog sections
  output rgbdsc_pkg::rgbdsc_code_t o_red_code,
  output rgbdsc_pkg::rgbdsc_code_t o_green_code,
  output rgbdsc_pkg::rgbdsc_code_t o_blue_code
);
  import rgbdsc_pkg::*;

  typedef enum logic [2:0] {
    I_IDLE, I_RX, I_RX_ACK, I_TX, I_TX_ACK, I_SKIP
  } rgbdsc_i2c_st_t;

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  logic [7:0] pin_s;
  logic sck_prev_q;
  logic sda_prev_q;
  rgbdsc_sync #(.W(8), .INIT(8'h8D)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({lnk.analog_mode, lnk.bus_type_select_pin,
              lnk.address_select_high_pin, lnk.address_select_low_pin,
              lnk.sclk, lnk.cs_n, lnk.mosi, lnk.sda}),
    .o_sync(pin_s)
  );
  wire sda_s = pin_s[0];
  wire mosi_s = pin_s[1];
  wire cs_n_s = pin_s[2];
  wire sck_s = pin_s[3];
  wire alo_s = pin_s[4];
  wire ahi_s = pin_s[5];
  wire bus_s = pin_s[6];
  wire ana_s = pin_s[7];
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // Clock idles high out of reset, so no false edge follows it
      sck_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      sda_prev_q <= sda_s;
    end
  end

  // R1: mode pin decode
  wire spi_mode = ~ana_s & bus_s;
  wire i2c_mode = ~ana_s & ~bus_s;

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  rgbdsc_code_t code_q [NUM_CH];

  // R3: colour to channel, 11 reads zero
  // Codes enter as arguments so a continuous caller follows every write
  function automatic rgbdsc_code_t pick(input rgbdsc_code_t r, input rgbdsc_code_t g,
                                        input rgbdsc_code_t b, input logic [1:0] c);
    case (c)
      COL_RED: pick = r;
      COL_GREEN: pick = g;
      COL_BLUE: pick = b;
      default: pick = CODE_RST;
    endcase
  endfunction

  // ----------------------------------------
  // SPI slave
  // ----------------------------------------
  logic [3:0] sbit_q;
  logic [7:0] ssh_q;
  logic [7:0] stx_q;
  logic [1:0] scol_q;
  logic srd_q;
  logic miso_q;
  wire [7:0] s_in = {ssh_q[6:0], mosi_s};
  // R5: only while select is low
  wire spi_live = spi_mode & ~cs_n_s;
  // R6: second byte ends at bit fifteen
  wire spi_wr = spi_live & sck_rise & (sbit_q == SPI_LAST_BIT) & ~srd_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sbit_q <= 4'h0;
      ssh_q <= 8'h00;
      stx_q <= 8'h00;
      scol_q <= COL_RED;
      srd_q <= 1'b0;
      miso_q <= 1'b0;
    end else if (!spi_live) begin
      // R19: abandon partial transfer
      sbit_q <= 4'h0;
      miso_q <= 1'b0;
    end else if (sck_rise) begin
      // R7: sample and launch on rising, MSB first
      sbit_q <= sbit_q + 4'h1;
      ssh_q <= s_in;
      // R4: output shifts alongside input
      miso_q <= stx_q[7];
      stx_q <= {stx_q[6:0], 1'b0};
      if (sbit_q == INS_LAST_BIT) begin
        // R8: direction and colour fields
        srd_q <= s_in[RW_POS];
        scol_q <= s_in[1:0];
        // R10: code leaves in bits 5:0
        stx_q <= {2'b00, pick(code_q[COL_RED], code_q[COL_GREEN], code_q[COL_BLUE], s_in[1:0])};
      end
    end
  end

  // ----------------------------------------
  // I2C slave
  // ----------------------------------------
  rgbdsc_i2c_st_t st_q;
  logic [3:0] ibit_q;
  logic [7:0] ish_q;
  logic [7:0] itx_q;
  logic [1:0] ibyte_q;
  logic [1:0] icol_q;
  logic irw_q;
  logic sda_oe_q;
  wire [7:0] i_in = {ish_q[6:0], sda_s};
  // R12: base address with two strap pins
  wire [6:0] my_addr = {I2C_BASE[6:2], ahi_s, alo_s};
  wire i2c_start = i2c_mode & sck_s & sck_prev_q & ~sda_s & sda_prev_q;
  wire i2c_stop = i2c_mode & sck_s & sck_prev_q & sda_s & ~sda_prev_q;
  wire byte_end = sck_fall & (st_q == I_RX) & (ibit_q == I2C_ACK_BIT);
  wire [7:0] tx_first = {2'b00, pick(code_q[COL_RED], code_q[COL_GREEN], code_q[COL_BLUE], icol_q)};
  // R15: first byte is address and direction
  wire hit_addr = ish_q[7:1] == my_addr;
  wire accept = (ibyte_q == 2'h0) ? hit_addr : ((ibyte_q != 2'h3) & ~irw_q);
  // R17: third write byte is the code
  wire i2c_wr = i2c_mode & byte_end & (ibyte_q == 2'h2) & ~irw_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= I_IDLE;
      ibit_q <= 4'h0;
      ish_q <= 8'h00;
      itx_q <= 8'h00;
      ibyte_q <= 2'h0;
      icol_q <= COL_RED;
      irw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (!i2c_mode || i2c_stop) begin
      st_q <= I_IDLE;
      sda_oe_q <= 1'b0;
    end else if (i2c_start) begin
      // Repeated start keeps the colour for a read
      st_q <= I_RX;
      ibit_q <= 4'h0;
      ibyte_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (sck_rise) begin
      if (st_q == I_RX) begin
        ish_q <= i_in;
        ibit_q <= ibit_q + 4'h1;
      end else if (st_q == I_TX) begin
        ibit_q <= ibit_q + 4'h1;
      end
    end else if (sck_fall) begin
      case (st_q)
        I_RX: begin
          if (ibit_q == I2C_ACK_BIT) begin
            if (ibyte_q == 2'h0) begin
              irw_q <= ish_q[0];
            end
            // R16: latch colour selector
            if (ibyte_q == 2'h1 && !irw_q) begin
              icol_q <= ish_q[1:0];
            end
            // R13: ack address, colour and code only
            if (accept) begin
              st_q <= I_RX_ACK;
              sda_oe_q <= 1'b1;
              ibyte_q <= ibyte_q + 2'h1;
            end else begin
              st_q <= I_SKIP;
            end
          end
        end
        I_RX_ACK: begin
          ibit_q <= 4'h0;
          if (irw_q) begin
            // R18: return code after repeated address
            st_q <= I_TX;
            itx_q <= tx_first;
            sda_oe_q <= ~tx_first[7];
          end else begin
            st_q <= I_RX;
            sda_oe_q <= 1'b0;
          end
        end
        I_TX: begin
          // R11: release for the master's ack slot
          if (ibit_q == I2C_ACK_BIT) begin
            st_q <= I_TX_ACK;
            sda_oe_q <= 1'b0;
          end else begin
            itx_q <= {itx_q[6:0], 1'b0};
            sda_oe_q <= ~itx_q[6];
          end
        end
        // R14: one code byte per read
        I_TX_ACK: st_q <= I_SKIP;
        default: st_q <= st_q;
      endcase
    end
  end

  // ----------------------------------------
  // Shared write port
  // ----------------------------------------
  wire wr_en = spi_wr | i2c_wr;
  wire [1:0] wr_col = spi_mode ? scol_q : icol_q;
  // R9: bits 7 and 6 ignored
  wire [CODE_W-1:0] wr_code = spi_mode ? s_in[CODE_W-1:0] : ish_q[CODE_W-1:0];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // R20: channels start at zero
      for (int i = 0; i < NUM_CH; i++) begin
        code_q[i] <= CODE_RST;
      end
    end else if (wr_en && wr_col < 2'(NUM_CH)) begin
      // R2: six-bit code per channel
      code_q[wr_col] <= wr_code;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_red_code = code_q[COL_RED];
  assign o_green_code = code_q[COL_GREEN];
  assign o_blue_code = code_q[COL_BLUE];
  assign lnk.miso = miso_q;
  // Open drain: only ever pulls low
  assign lnk.dev_sda_o = 1'b0;
  assign lnk.dev_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// ---- verilog/rgbdsc_host.sv ----
`default_nettype none
module rgbdsc_host #(
  parameter int QUARTER = rgbdsc_pkg::QUARTER_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rgbdsc_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial link
  rgbdsc_if.host lnk
);
  import rgbdsc_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} rgbdsc_host_st_t;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic go_q;
  logic nack_q;
  rgbdsc_code_t rcode_q;
  rgbdsc_host_st_t st_q;
  wire busy = (st_q != H_IDLE) | go_q;
  wire setup = i_psel & ~i_penable & ~o_pready;
  wire access = i_psel & i_penable & o_pready;
  wire hit_ctrl = i_paddr == CTRL_OFS;
  wire hit_stat = i_paddr == STAT_OFS;
  // Writes to control are dropped while a transfer runs
  wire wr_ok = access & i_pwrite & hit_ctrl & ~busy;
  wire [31:0] stat_w = {18'h0, rcode_q, 6'h0, nack_q, busy};
  wire [31:0] rd_w = hit_ctrl ? ctrl_q : (hit_stat ? stat_w : 32'h0);
  wire c_rd = ctrl_q[CTRL_RD];
  wire c_spi = ctrl_q[CTRL_SPI];
  wire [1:0] c_col = ctrl_q[CTRL_COL +: 2];
  wire [5:0] c_code = ctrl_q[CTRL_CODE +: CODE_W];
  wire [6:0] addr7 = {I2C_BASE[6:2], ctrl_q[CTRL_AHI], ctrl_q[CTRL_ALO]};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
      ctrl_q <= CTRL_RST;
      go_q <= 1'b0;
    end else begin
      o_pready <= setup;
      go_q <= wr_ok & i_pwdata[CTRL_GO];
      if (setup) begin
        o_prdata <= rd_w;
        o_pslverr <= ~(hit_ctrl | hit_stat);
      end
      if (wr_ok) begin
        ctrl_q <= i_pwdata & CTRL_WMASK;
      end
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  logic [1:0] rx_s;
  logic [7:0] qcnt_q;
  logic [1:0] ph_q;
  logic [4:0] bit_q;
  logic [1:0] byte_q;
  logic [15:0] tx_q;
  logic [7:0] rx_q;
  logic ack_q;
  logic scl_q;
  logic cs_q;
  logic mosi_q;
  logic oe_q;
  rgbdsc_sync #(.W(2), .INIT(2'h1)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({lnk.miso, lnk.sda}),
    .o_sync(rx_s)
  );
  wire tick = qcnt_q == 8'(QUARTER - 1);
  wire mid = (ph_q == 2'h1) | (ph_q == 2'h2);
  wire ack_slot = ~c_spi & (bit_q == 5'h8);
  wire last_bit = c_spi ? (bit_q == 5'hF) : ack_slot;
  wire done = (byte_q == 2'h3) | ((byte_q == 2'h2) & ~c_rd);

  // R13: write bytes; R14: read bytes with repeated address
  function automatic logic [7:0] i2c_byte(input logic [1:0] idx, input logic rd,
                                          input logic [6:0] a, input logic [1:0] col,
                                          input logic [5:0] code);
    case (idx)
      // R15: address and direction first
      2'h0: i2c_byte = {a, 1'b0};
      // R16: colour selector second
      2'h1: i2c_byte = {6'h0, col};
      2'h2: i2c_byte = rd ? {a, 1'b1} : {2'b00, code};
      default: i2c_byte = 8'hFF;
    endcase
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= H_IDLE;
      qcnt_q <= 8'h0;
      ph_q <= 2'h0;
      bit_q <= 5'h0;
      byte_q <= 2'h0;
      tx_q <= 16'h0;
      rx_q <= 8'h0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      rcode_q <= CODE_RST;
    end else begin
      qcnt_q <= (st_q == H_IDLE || tick) ? 8'h0 : qcnt_q + 8'h1;
      if (go_q) begin
        st_q <= H_START;
        ph_q <= 2'h0;
        bit_q <= 5'h0;
        byte_q <= 2'h0;
        nack_q <= 1'b0;
        // R8: instruction fields; R3: colour codes
        tx_q <= c_spi ? {c_rd, 5'h0, c_col, 2'b00, c_code}
                      : {i2c_byte(2'h0, c_rd, addr7, c_col, c_code), 8'hFF};
      end else if (st_q != H_IDLE && tick) begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          H_START: st_q <= (ph_q == 2'h3) ? H_BIT : H_START;
          H_BIT: begin
            if (ph_q == 2'h2 && ack_slot) begin
              ack_q <= ~rx_s[0];
            end else if (ph_q == 2'h2) begin
              // R7: sample late in the high phase
              rx_q <= {rx_q[6:0], c_spi ? rx_s[1] : rx_s[0]};
            end
            if (ph_q == 2'h3 && !last_bit) begin
              bit_q <= bit_q + 5'h1;
              tx_q <= {tx_q[14:0], 1'b0};
            end else if (ph_q == 2'h3) begin
              bit_q <= 5'h0;
              if (c_spi || byte_q == 2'h3) begin
                // R6: two bytes then select rises
                st_q <= H_STOP;
                rcode_q <= c_rd ? rx_q[5:0] : rcode_q;
              end else if (!ack_q) begin
                nack_q <= 1'b1;
                st_q <= H_STOP;
              end else if (done) begin
                st_q <= H_STOP;
              end else begin
                byte_q <= byte_q + 2'h1;
                tx_q <= {i2c_byte(byte_q + 2'h1, c_rd, addr7, c_col, c_code), 8'hFF};
                st_q <= (byte_q == 2'h1 && c_rd) ? H_START : H_BIT;
              end
            end
          end
          H_STOP: st_q <= (ph_q == 2'h3) ? H_IDLE : H_STOP;
          default: st_q <= H_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic scl_d;
  logic cs_d;
  logic mosi_d;
  logic oe_d;
  always_comb begin
    scl_d = ~c_spi;
    cs_d = 1'b1;
    mosi_d = 1'b0;
    oe_d = 1'b0;
    case (st_q)
      H_START: begin
        // R5: select low before the first clock
        cs_d = ~c_spi;
        scl_d = ~c_spi & mid;
        oe_d = ~c_spi & ph_q[1];
      end
      H_BIT: begin
        cs_d = ~c_spi;
        scl_d = mid;
        // R9: data byte carries code in bits 5:0
        mosi_d = c_spi & tx_q[15];
        oe_d = ~c_spi & ~ack_slot & ~tx_q[15];
      end
      H_STOP: begin
        cs_d = ~c_spi | ph_q[1];
        scl_d = ~c_spi & (ph_q != 2'h0);
        oe_d = ~c_spi & ~ph_q[1];
      end
      default: scl_d = ~c_spi;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_q <= 1'b1;
      cs_q <= 1'b1;
      mosi_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      scl_q <= scl_d;
      cs_q <= cs_d;
      mosi_q <= mosi_d;
      oe_q <= oe_d;
    end
  end

  assign lnk.sclk = scl_q;
  assign lnk.cs_n = cs_q;
  assign lnk.mosi = mosi_q;
  assign lnk.host_sda_o = 1'b0;
  assign lnk.host_sda_oe = oe_q;
  // R1: digital control and bus choice from control
  assign lnk.analog_mode = ctrl_q[CTRL_ANA];
  assign lnk.bus_type_select_pin = ctrl_q[CTRL_SPI];
  assign lnk.address_select_high_pin = ctrl_q[CTRL_AHI];
  assign lnk.address_select_low_pin = ctrl_q[CTRL_ALO];
endmodule
`default_nettype wire

// ---- verilog/rgbdsc_sync.sv ----
`default_nettype none
module rgbdsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pins and their synchronised copies
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import rgbdsc_pkg::*;
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= INIT;
      o_sync <= INIT;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire
